/* bench/dma_prog_asserts.sv */
// Checker for the DMA programming block ports
`timescale 1ns/100ps
module dma_prog_asserts (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        processor_reset,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic [7:0]  transfer_acknowledge,
  input wire logic [7:0]  chan_decrement,
  input wire logic [7:0]  chan_autoinit,
  input wire logic [15:0] chan_xfer_mode,
  input wire logic [15:0] chan_xfer_type
);
  wire  rst = sys_rst | processor_reset;
  logic lo_pol_r;
  logic up_pol_r;
  logic up_dis_r;
  // Shadow of the command bits that fix acknowledge levels
  always_ff @(posedge sys_clk)
    if (rst) lo_pol_r <= 1'b0;
    else if (io_wr && io_addr == 8'h08) lo_pol_r <= io_wdata[7];
  always_ff @(posedge sys_clk)
    if (rst) {up_pol_r, up_dis_r} <= 2'h0;
    else if (io_wr && io_addr == 8'hD0) {up_pol_r, up_dis_r} <= {io_wdata[7], io_wdata[2]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_mode_wr(ch);
    io_wr && io_addr == 8'h0B && io_wdata[1:0] == ch;
  endsequence
  property p_rst_clear;
    disable iff (1'b0) rst |=> chan_xfer_mode == 16'h0000 && chan_autoinit == 8'h00
      && transfer_acknowledge == 8'hFF;
  endproperty
  property p_mode_wr;
    s_mode_wr(2'h0) ##0 io_wdata[7:6] != 2'h3 |=> chan_xfer_mode[1:0] == $past(io_wdata[7:6])
      && chan_xfer_type[1:0] == $past(io_wdata[3:2]);
  endproperty
  property p_mode_bits;
    s_mode_wr(2'h0) |=> {chan_decrement[0], chan_autoinit[0]} == $past(io_wdata[5:4]);
  endproperty
  property p_casc;
    s_mode_wr(2'h3) ##0 io_wdata[7:6] == 2'h3 |=> chan_xfer_type[7:6] == 2'h0;
  endproperty
  property p_sel_only;
    s_mode_wr(2'h1) |=> $stable(chan_xfer_mode[1:0]) && $stable(chan_xfer_mode[15:8]);
  endproperty
  property p_ack4;
    transfer_acknowledge[4] == ~up_pol_r;
  endproperty
  property p_up_off;
    up_dis_r [*4] |-> transfer_acknowledge[3:0] == {4{~lo_pol_r}}
      && transfer_acknowledge[7:5] == {3{~up_pol_r}};
  endproperty
  property p_rd_refuse;
    io_rd && io_addr != 8'h08 && io_addr != 8'hD0 |=> io_rdata == 8'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset values wrong");
  a_mode_wr: assert property (p_mode_wr) else $error("mode or type not stored");
  a_mode_bits: assert property (p_mode_bits) else $error("step or autoinit wrong");
  a_casc: assert property (p_casc) else $error("cascade type not ignored");
  a_sel_only: assert property (p_sel_only) else $error("other channel mode moved");
  a_ack4: assert property (p_ack4) else $error("channel 4 ack not idle");
  a_up_off: assert property (p_up_off) else $error("ack while upper disabled");
  a_rd_refuse: assert property (p_rd_refuse) else $error("unmapped read not zero");
endmodule

/* bench/isa_dev_model.sv */
// Peripheral model driving request lines at the chosen sense level
`timescale 1ns/100ps
module isa_dev_model (
  input  wire logic       sys_clk,
  input  wire logic       req_low,
  input  wire logic [7:0] want,
  output logic      [7:0] transfer_request = 8'h00
);
  always_ff @(posedge sys_clk)
    transfer_request <= want ^ {8{req_low}};
endmodule

/* bench/test_cascaded_dma_channel_programming.sv */
// Testbench for the cascaded DMA programming block
`timescale 1ns/100ps
module test_cascaded_dma_channel_programming;
  logic        sys_clk = 0, sys_rst = 1, processor_reset = 0, io_wr = 0, io_rd = 0;
  logic        obs = 0, seen = 0, req_low = 0;
  logic [7:0]  io_addr = 0, io_wdata = 0, want = 0, terminal_count = 0, lfsr = 8'h3A, d;
  wire  [7:0]  io_rdata, transfer_request, transfer_acknowledge, chan_decrement, chan_autoinit;
  wire  [15:0] chan_xfer_mode, chan_xfer_type;
  logic [15:0] em = 0, et = 0, ed = 0, o;
  logic [18:0] q[$];
  int          error_cnt = 0, compares = 0;
  string       nm[5] = '{"rdata", "ack", "mode", "type", "dec_auto"};
  always #10 sys_clk = ~sys_clk;
  dma_prog_top dut (.sys_clk, .sys_rst, .processor_reset, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .transfer_request, .terminal_count, .transfer_acknowledge,
    .chan_xfer_mode, .chan_decrement, .chan_autoinit, .chan_xfer_type);
  isa_dev_model far (.sys_clk, .req_low, .want, .transfer_request);
  function automatic [7:0] nx(input [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic wr(input [7:0] a, input [7:0] v);
    @(posedge sys_clk);
    io_wr <= 1;
    io_addr <= a;
    io_wdata <= v;
    @(posedge sys_clk);
    io_wr <= 0;
  endtask
  task automatic chk(input [2:0] s, input [15:0] v);
    q.push_back({s, v});
    obs <= ~obs;
    @(posedge sys_clk);
  endtask
  task automatic rd(input [7:0] a, input [7:0] v);
    @(posedge sys_clk);
    io_rd <= 1;
    io_addr <= a;
    @(posedge sys_clk);
    io_rd <= 0;
    chk(0, {8'h00, v});
  endtask
  task automatic tc_pulse();
    terminal_count <= 8'h02;
    @(posedge sys_clk);
    terminal_count <= 8'h00;
    want <= 8'h00;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Oldest note is compared once outputs have settled
  always @(negedge sys_clk) begin
    if (obs != seen) begin
      logic [18:0] e;
      seen <= obs;
      e = q.pop_front();
      compares++;
      case (e[18:16])
        0: o = {8'h00, io_rdata};
        1: o = {8'h00, transfer_acknowledge};
        2: o = chan_xfer_mode;
        3: o = chan_xfer_type;
        default: o = {chan_decrement, chan_autoinit};
      endcase
      if (o !== e[15:0]) begin
        error_cnt++;
        $display("ERROR %s expected %h seen %h", nm[e[18:16]], e[15:0], o);
      end
    end
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 0;
    chk(1, 16'h00FF);
    chk(2, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      lfsr = nx(lfsr);
      d = {c[1:0], lfsr[5:2], c[1:0]};
      // Transfer type 11 is illegal, so random types stay legal
      if (d[3:2] == 2'h3) d[3] = 1'b0;
      wr(c < 4 ? 8'h0B : 8'hD6, d);
      em[2*c+:2] = c[1:0];
      et[2*c+:2] = (c[1:0] == 2'h3) ? 2'h0 : d[3:2];
      ed[c+8] = d[5];
      ed[c] = d[4];
    end
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    chk(2, em);
    chk(3, et);
    chk(4, ed);
    wr(8'hD6, 8'hC0);
    wr(8'h0B, 8'h81);
    wr(8'h0A, 8'h01);
    wr(8'hD4, 8'h00);
    want <= 8'h02;
    repeat (4) @(posedge sys_clk);
    chk(1, 16'h00FD);
    rd(8'h08, 8'h20);
    wr(8'hD4, 8'h04);
    repeat (3) @(posedge sys_clk);
    chk(1, 16'h00FF);
    wr(8'hD4, 8'h00);
    wr(8'hD0, 8'h04);
    repeat (4) @(posedge sys_clk);
    chk(1, 16'h00FF);
    wr(8'hD0, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk(1, 16'h00FD);
    tc_pulse();
    chk(1, 16'h00FF);
    rd(8'h08, 8'h02);
    wr(8'h09, 8'h05);
    repeat (4) @(posedge sys_clk);
    chk(1, 16'h00FD);
    rd(8'h08, 8'h20);
    tc_pulse();
    rd(8'h08, 8'h02);
    wr(8'h08, 8'h80);
    chk(1, 16'h00F0);
    wr(8'h0A, 8'h02);
    want <= 8'h04;
    req_low <= 1;
    wr(8'h08, 8'hC0);
    repeat (4) @(posedge sys_clk);
    chk(1, 16'h00F4);
    wr(8'h0F, 8'h0F);
    repeat (3) @(posedge sys_clk);
    chk(1, 16'h00F0);
    wr(8'h0F, 8'h0B);
    repeat (3) @(posedge sys_clk);
    chk(1, 16'h00F4);
    // Serve channel 0 alone, then raise 0 and 2 together: rotation picks 2
    wr(8'h08, 8'hD0);
    wr(8'h0F, 8'h0A);
    want <= 8'h01;
    repeat (4) @(posedge sys_clk);
    want <= 8'h00;
    repeat (4) @(posedge sys_clk);
    want <= 8'h05;
    repeat (4) @(posedge sys_clk);
    chk(1, 16'h00F4);
    processor_reset <= 1;
    @(posedge sys_clk);
    processor_reset <= 0;
    chk(1, 16'h00FF);
    chk(2, 16'h0000);
    results();
  end
endmodule
bind dma_prog_top dma_prog_asserts chk_i (.sys_clk, .sys_rst, .processor_reset, .io_wr,
  .io_rd, .io_addr, .io_wdata, .io_rdata, .transfer_acknowledge, .chan_decrement,
  .chan_autoinit, .chan_xfer_mode, .chan_xfer_type);

/* src/dma_arbiter.sv */
// Four-channel arbiter with fixed or rotating priority
`timescale 1ns/100ps
module dma_arbiter (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] req,
  input  wire logic       enable,
  input  wire logic       rotate,
  output logic      [3:0] grant
);
  dma_prog_pkg::arb_state_t state_r;
  logic [3:0] grant_r;
  logic [1:0] top_r;
  logic [1:0] top_nxt;
  logic [3:0] pick;

  // First requester at or after the highest-priority slot
  always_comb begin
    logic [1:0] idx;
    logic       found;
    idx   = 2'h0;
    found = 1'b0;
    pick  = 4'h0;
    for (int k = 0; k < 4; k++) begin
      idx = top_nxt + k[1:0];
      if (!found && req[idx]) begin
        pick[idx] = 1'b1;
        found     = 1'b1;
      end
    end
  end

  // Fixed priority keeps channel 0 on top
  assign top_nxt = rotate ? top_r : 2'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= dma_prog_pkg::ARB_IDLE;
      grant_r <= 4'h0;
    end else begin
      case (state_r)
        dma_prog_pkg::ARB_IDLE: begin
          if (enable && (req != 4'h0)) begin
            grant_r <= pick;
            state_r <= dma_prog_pkg::ARB_GRANT;
          end
        end
        dma_prog_pkg::ARB_GRANT: begin
          if (!enable || ((grant_r & req) == 4'h0)) begin
            grant_r <= 4'h0;
            state_r <= dma_prog_pkg::ARB_IDLE;
          end
        end
        default: begin
          grant_r <= 4'h0;
          state_r <= dma_prog_pkg::ARB_IDLE;
        end
      endcase
    end
  end

  // Serviced channel drops to lowest priority
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      top_r <= 2'h0;
    end else if (state_r == dma_prog_pkg::ARB_GRANT && (grant_r & req) == 4'h0) begin
      for (int k = 0; k < 4; k++) begin
        if (grant_r[k]) begin
          top_r <= k[1:0] + 2'h1;
        end
      end
    end
  end

  assign grant = grant_r;
endmodule

/* src/dma_port_decode.sv */
// I/O port decoder for both controllers
`timescale 1ns/100ps
`include "dma_prog_defines.svh"
module dma_port_decode (
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  dma_strobe_if.dec       stb
);
  always_comb begin
    stb.wdata       = io_wdata;
    stb.wr_cmd[0]   = io_wr && (io_addr == `LO_CMD_ADDR);
    stb.wr_cmd[1]   = io_wr && (io_addr == `UP_CMD_ADDR);
    stb.wr_req[0]   = io_wr && (io_addr == `LO_REQ_ADDR);
    stb.wr_req[1]   = io_wr && (io_addr == `UP_REQ_ADDR);
    stb.wr_smask[0] = io_wr && (io_addr == `LO_SMASK_ADDR);
    stb.wr_smask[1] = io_wr && (io_addr == `UP_SMASK_ADDR);
    stb.wr_mode[0]  = io_wr && (io_addr == `LO_MODE_ADDR);
    stb.wr_mode[1]  = io_wr && (io_addr == `UP_MODE_ADDR);
    stb.wr_amask[0] = io_wr && (io_addr == `LO_AMASK_ADDR);
    stb.wr_amask[1] = io_wr && (io_addr == `UP_AMASK_ADDR);
    stb.rd_stat[0]  = io_rd && (io_addr == `LO_CMD_ADDR);
    stb.rd_stat[1]  = io_rd && (io_addr == `UP_CMD_ADDR);
  end
endmodule

/* src/dma_prog_defines.svh */
// Port addresses, field positions, reset values for the cascaded DMA programming block
`ifndef DMA_PROG_DEFINES_SVH
`define DMA_PROG_DEFINES_SVH

`define LO_CMD_ADDR    8'h08
`define LO_REQ_ADDR    8'h09
`define LO_SMASK_ADDR  8'h0A
`define LO_MODE_ADDR   8'h0B
`define LO_AMASK_ADDR  8'h0F
`define UP_CMD_ADDR    8'hD0
`define UP_REQ_ADDR    8'hD2
`define UP_SMASK_ADDR  8'hD4
`define UP_MODE_ADDR   8'hD6
`define UP_AMASK_ADDR  8'hDE

`define CMD_ACK_POL    7
`define CMD_REQ_LOW    6
`define CMD_ROTATE     4
`define CMD_DISABLE    2
`define WR_SET_BIT     2
`define MODE_DEC_BIT   5
`define MODE_AUTO_BIT  4

`define CMD_RESET      8'h00
`define MODE_RESET     6'h00
`define MASK_RESET     1'b1
`define TYPE_IGNORED   2'h0

`endif

/* src/dma_prog_pkg.sv */
// Types shared by the DMA programming block
package dma_prog_pkg;

  typedef enum logic [1:0] {
    MODE_DEMAND  = 2'h0,
    MODE_SINGLE  = 2'h1,
    MODE_BLOCK   = 2'h2,
    MODE_CASCADE = 2'h3
  } xfer_mode_t;

  typedef enum logic [1:0] {
    ARB_IDLE  = 2'b01,
    ARB_GRANT = 2'b10
  } arb_state_t;

endpackage

/* src/dma_prog_top.sv */
// Cascaded two-controller DMA programming registers, request sensing and arbitration
`timescale 1ns/100ps
`include "dma_prog_defines.svh"
module dma_prog_top (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        processor_reset,
  input  wire logic [7:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic [7:0]  transfer_request,
  input  wire logic [7:0]  terminal_count,
  output logic      [7:0]  transfer_acknowledge,
  output logic      [15:0] chan_xfer_mode,
  output logic      [7:0]  chan_decrement,
  output logic      [7:0]  chan_autoinit,
  output logic      [15:0] chan_xfer_type
);
  logic       rst;
  logic [7:0] cmd_r [2];
  logic [5:0] mode_r [8];
  logic [7:0] sreq_r;
  logic [7:0] mask_r;
  logic [7:0] tcst_r;
  logic [7:0] hw_req;
  logic [7:0] pend;
  logic [7:0] eff_req;
  logic [1:0] grp_en;
  logic [3:0] lo_grant;
  logic [3:0] up_grant;
  logic [7:0] grant;
  logic [7:0] rdata_r;
  logic       cascade_req;

  dma_strobe_if stb ();

  // Processor reset and system reset both load defaults
  assign rst = sys_rst | processor_reset;

  dma_port_decode u_decode (
    .io_addr  (io_addr),
    .io_wr    (io_wr),
    .io_rd    (io_rd),
    .io_wdata (io_wdata),
    .stb      (stb)
  );

  // Command registers
  generate
    for (genvar c = 0; c < 2; c++) begin : g_cmd
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cmd_r[c] <= `CMD_RESET;
        end else if (stb.wr_cmd[c]) begin
          cmd_r[c] <= stb.wdata;
        end
      end
    end
  endgenerate

  // Upper disable also shuts the lower group
  assign grp_en[1] = ~cmd_r[1][`CMD_DISABLE];
  assign grp_en[0] = ~cmd_r[0][`CMD_DISABLE] & grp_en[1];

  // Lower requests reach the upper controller through channel 4
  assign cascade_req = |eff_req[3:0];

  generate
    for (genvar i = 0; i < 8; i++) begin : g_chan
      localparam int C = i / 4;
      localparam logic [1:0] SEL = 2'(i % 4);
      logic sel_hit;

      assign sel_hit = (stb.wdata[1:0] == SEL);

      // Channel mode register
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          mode_r[i] <= `MODE_RESET;
        end else if (stb.wr_mode[C] && sel_hit) begin
          mode_r[i][5:4] <= stb.wdata[7:6];
          mode_r[i][3]   <= stb.wdata[`MODE_DEC_BIT];
          mode_r[i][2]   <= stb.wdata[`MODE_AUTO_BIT];
          if (stb.wdata[7:6] == dma_prog_pkg::MODE_CASCADE) begin
            mode_r[i][1:0] <= `TYPE_IGNORED;
          end else begin
            mode_r[i][1:0] <= stb.wdata[3:2];
          end
        end
      end

      // Software request: a write beats a same-cycle terminal count
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sreq_r[i] <= 1'b0;
        end else if (stb.wr_req[C] && sel_hit) begin
          sreq_r[i] <= stb.wdata[`WR_SET_BIT];
        end else if (terminal_count[i]) begin
          sreq_r[i] <= 1'b0;
        end
      end

      // Mask bit: automatic set on terminal count wins over a clear
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          mask_r[i] <= `MASK_RESET;
        end else if (terminal_count[i] && !mode_r[i][2]) begin
          mask_r[i] <= 1'b1;
        end else if (stb.wr_smask[C] && sel_hit) begin
          mask_r[i] <= stb.wdata[`WR_SET_BIT];
        end else if (stb.wr_amask[C]) begin
          mask_r[i] <= stb.wdata[SEL];
        end
      end

      // Terminal count status, cleared by a status read
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          tcst_r[i] <= 1'b0;
        end else if (terminal_count[i]) begin
          tcst_r[i] <= 1'b1;
        end else if (stb.rd_stat[C]) begin
          tcst_r[i] <= 1'b0;
        end
      end

      // Request sensing and effective request
      if (i == 4) begin : g_casc
        assign hw_req[i]  = cascade_req;
        assign pend[i]    = cascade_req | sreq_r[i];
        assign eff_req[i] = (hw_req[i] & ~mask_r[i]) | sreq_r[i];
      end else begin : g_pin
        assign hw_req[i] = transfer_request[i] ^ cmd_r[C][`CMD_REQ_LOW];
        assign pend[i]   = hw_req[i] | sreq_r[i];
        if (C == 0) begin : g_lo
          // Upper channel 0 mask blocks the lower hardware requests
          assign eff_req[i] = (hw_req[i] & ~mask_r[i] & ~mask_r[4]) | sreq_r[i];
        end else begin : g_up
          assign eff_req[i] = (hw_req[i] & ~mask_r[i]) | sreq_r[i];
        end
      end

      // Acknowledge pin with programmed polarity; channel 4 has no pin
      if (i == 4) begin : g_noack
        assign transfer_acknowledge[i] = ~cmd_r[C][`CMD_ACK_POL];
      end else begin : g_ack
        assign transfer_acknowledge[i] = grant[i] ? cmd_r[C][`CMD_ACK_POL]
                                                  : ~cmd_r[C][`CMD_ACK_POL];
      end

      assign chan_xfer_mode[2*i +: 2] = mode_r[i][5:4];
      assign chan_decrement[i]        = mode_r[i][3];
      assign chan_autoinit[i]         = mode_r[i][2];
      assign chan_xfer_type[2*i +: 2] = mode_r[i][1:0];
    end
  endgenerate

  dma_arbiter u_arb_lo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .req     (eff_req[3:0]),
    .enable  (grp_en[0]),
    .rotate  (cmd_r[0][`CMD_ROTATE]),
    .grant   (lo_grant)
  );

  dma_arbiter u_arb_up (
    .sys_clk (sys_clk),
    .rst     (rst),
    .req     (eff_req[7:4]),
    .enable  (grp_en[1]),
    .rotate  (cmd_r[1][`CMD_ROTATE]),
    .grant   (up_grant)
  );

  // Lower acknowledges only pass while the upper controller serves channel 4
  assign grant = {up_grant, lo_grant & {4{up_grant[0]}}};

  // Status read data, registered; other reads return zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (stb.rd_stat[0]) begin
      rdata_r <= {pend[3:0], tcst_r[3:0]};
    end else if (stb.rd_stat[1]) begin
      rdata_r <= {pend[7:4], tcst_r[7:4]};
    end else if (io_rd) begin
      rdata_r <= 8'h00;
    end
  end

  assign io_rdata = rdata_r;
endmodule

/* src/dma_strobe_if.sv */
// Decoded register write and status read strobes, one bit per controller
`timescale 1ns/100ps
interface dma_strobe_if;
  logic [1:0] wr_cmd;
  logic [1:0] wr_mode;
  logic [1:0] wr_req;
  logic [1:0] wr_smask;
  logic [1:0] wr_amask;
  logic [1:0] rd_stat;
  logic [7:0] wdata;

  modport dec  (output wr_cmd, wr_mode, wr_req, wr_smask, wr_amask, rd_stat, wdata);
  modport core (input  wr_cmd, wr_mode, wr_req, wr_smask, wr_amask, rd_stat, wdata);
endinterface
